// ### rtl/countdown_timer_32bit.sv
// 32-bit countdown timer with an AXI4-Lite register slave
// How it works
// - a 32-bit down counter raises an interrupt event whenever it reaches zero
// - free-running mode reloads all ones on reaching zero
// - user count mode reloads the reload register value on reaching zero
// - on going from disabled to enabled the counter loads the reload register
// - everything runs in one clock domain, the timer's own clock
// - reset disables timer, unmasks interrupt, picks free-run, clears reload value
// - reading the acknowledge register clears the pending interrupt
// - the state register shows interrupt status without clearing it
// - interrupt output ORs the pending flag gated by the mask bit with the event bit gated by the event mask
// - disabling the timer clears the pending flag but not the event bit
// - mode bit 1 selects user count mode, 0 free-running
// - mask bit 1 keeps the pending flag off the interrupt output
// - clearing enable resets the counter and pending state
// - a zero event in the cycle of a clear keeps the interrupt set
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`default_nettype none
module countdown_timer_32bit #(
    parameter int CNT_W = cdt_pkg::CNT_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt
    output logic timerIrq
);
    // registers
    logic [CNT_W-1:0] reloadValue_r;
    logic [CNT_W-1:0] count_r;
    cdt_pkg::control_s control_r;
    logic runEnPrev_r;
    logic pending_r;
    logic evtStat_r;
    logic evtMask_r;
    logic [7:0] awAddr_r;
    logic awHeld_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic wHeld_r;
    logic bValid_r;
    logic [1:0] bResp_r;
    logic rValid_r;
    logic [31:0] rData_r;
    logic [1:0] rResp_r;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // write channel: address and data accepted independently
    // bvalid blocks doWrite, so one write lands per response
    wire doWrite = awHeld_r && wHeld_r && !bValid_r;
    wire wrReload = doWrite && awAddr_r == cdt_pkg::RELOAD_OFS;
    wire wrControl = doWrite && awAddr_r == cdt_pkg::CONTROL_OFS;
    wire wrEvtMask = doWrite && awAddr_r == cdt_pkg::EVTMASK_OFS;
    wire wrHit = awAddr_r == cdt_pkg::RELOAD_OFS || awAddr_r == cdt_pkg::CONTROL_OFS
        || awAddr_r == cdt_pkg::EVTMASK_OFS;
    wire [31:0] ctlMerged = merge({29'h0, control_r}, wData_r, wStrb_r);
    wire [31:0] reloadMerged = merge(reloadValue_r, wData_r, wStrb_r);
    wire [31:0] maskMerged = merge({31'h0, evtMask_r}, wData_r, wStrb_r);

    assign s_axi_awready = !awHeld_r;
    assign s_axi_wready = !wHeld_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;

    // read channel
    wire doRead = s_axi_arvalid && !rValid_r;
    assign s_axi_arready = !rValid_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata = rData_r;
    assign s_axi_rresp = rResp_r;
    wire rdAck = doRead && s_axi_araddr == cdt_pkg::ACK_OFS;
    wire rdEvtStat = doRead && s_axi_araddr == cdt_pkg::EVTSTAT_OFS;

    // unmapped reads answer zero with an error response
    logic [31:0] rdMux;
    logic rdHit;
    always_comb begin
        rdHit = 1'b1;
        rdMux = 32'h0000_0000;
        if (s_axi_araddr == cdt_pkg::RELOAD_OFS) begin
            rdMux = reloadValue_r;
        end else if (s_axi_araddr == cdt_pkg::COUNT_OFS) begin
            rdMux = count_r;
        end else if (s_axi_araddr == cdt_pkg::CONTROL_OFS) begin
            rdMux = {29'h0, control_r};
        end else if (s_axi_araddr == cdt_pkg::ACK_OFS) begin
            rdMux = 32'h0000_0000;
        end else if (s_axi_araddr == cdt_pkg::STATE_OFS) begin
            rdMux = {31'h0, pending_r && !control_r.irqMask};
        end else if (s_axi_araddr == cdt_pkg::EVTSTAT_OFS) begin
            rdMux = {31'h0, evtStat_r};
        end else if (s_axi_araddr == cdt_pkg::EVTMASK_OFS) begin
            rdMux = {31'h0, evtMask_r};
        end else begin
            rdHit = 1'b0;
        end
    end

    // counter control
    wire runEn = control_r.runEnable;
    wire enRise = runEn && !runEnPrev_r;
    // no zero event in the load cycle: the count is stale then
    wire atZero = runEn && !enRise && count_r == '0;
    wire [CNT_W-1:0] reloadSel = control_r.countMode ? reloadValue_r
        : CNT_W'(cdt_pkg::FREE_MAX);
    logic [CNT_W-1:0] count_nxt;
    always_comb begin
        if (!runEn) begin
            count_nxt = '0;
        end else if (enRise) begin
            count_nxt = reloadValue_r;
        end else if (atZero) begin
            count_nxt = reloadSel;
        end else begin
            count_nxt = count_r - CNT_W'(1);
        end
    end

    // pending flag: set beats clear
    // disable wins over both, so the flag cannot outlive the timer
    wire pending_nxt = !runEn ? 1'b0
        : atZero ? 1'b1
        : rdAck ? 1'b0 : pending_r;
    // sticky copy for polling; its own mask keeps it off the pin
    wire evtStat_nxt = atZero ? 1'b1 : (rdEvtStat ? 1'b0 : evtStat_r);

    // single clock domain for counter and bus
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= '0;
            runEnPrev_r <= 1'b0;
            pending_r <= 1'b0;
            evtStat_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            runEnPrev_r <= runEn;
            pending_r <= pending_nxt;
            evtStat_r <= evtStat_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reloadValue_r <= CNT_W'(cdt_pkg::RELOAD_RST);
            control_r <= cdt_pkg::CONTROL_RST;
            evtMask_r <= cdt_pkg::EVTMASK_RST;
        end else begin
            if (wrReload) begin
                reloadValue_r <= reloadMerged[CNT_W-1:0];
            end
            if (wrControl) begin
                control_r <= ctlMerged[2:0];
            end
            if (wrEvtMask) begin
                evtMask_r <= maskMerged[0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wHeld_r <= 1'b0;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            bValid_r <= 1'b0;
            bResp_r <= cdt_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !awHeld_r) begin
                awHeld_r <= 1'b1;
                awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !wHeld_r) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                bValid_r <= 1'b1;
                bResp_r <= wrHit ? cdt_pkg::RESP_OKAY : cdt_pkg::RESP_SLVERR;
            end else if (bValid_r && s_axi_bready) begin
                bValid_r <= 1'b0;
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rValid_r <= 1'b0;
            rData_r <= 32'h0000_0000;
            rResp_r <= cdt_pkg::RESP_OKAY;
        end else if (doRead) begin
            rValid_r <= 1'b1;
            rData_r <= rdMux;
            rResp_r <= rdHit ? cdt_pkg::RESP_OKAY : cdt_pkg::RESP_SLVERR;
        end else if (rValid_r && s_axi_rready) begin
            rValid_r <= 1'b0;
        end
    end

    // interrupt: timer flag gated by control mask, sticky event gated by event mask
    // limitation: an unmasked event bit keeps the pin up after disable
    assign timerIrq = (pending_r && !control_r.irqMask) || (evtStat_r && !evtMask_r);

    // marks a reset that has already reached the registers
    logic heldRst_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            heldRst_r <= 1'b1;
        end else begin
            heldRst_r <= 1'b0;
        end
    end

    // checks
    chk_zero_reload: assert property (@(posedge core_clk) disable iff (!resetn)
        (atZero && !control_r.countMode) |=> count_r == cdt_pkg::FREE_MAX)
        else $error("free-run reload wrong");
    chk_user_reload: assert property (@(posedge core_clk) disable iff (!resetn)
        (atZero && control_r.countMode) |=> count_r == $past(reloadValue_r))
        else $error("user reload wrong");
    chk_enable_load: assert property (@(posedge core_clk) disable iff (!resetn)
        enRise |=> count_r == $past(reloadValue_r))
        else $error("enable load wrong");
    chk_decrement_step: assert property (@(posedge core_clk) disable iff (!resetn)
        (runEn && !enRise && count_r != '0 && $past(runEn)) |=> count_r == $past(count_r) - 1)
        else $error("decrement wrong");
    chk_set_wins: assert property (@(posedge core_clk) disable iff (!resetn)
        (atZero && rdAck) |=> pending_r)
        else $error("clear beat set");
    chk_ack_clears: assert property (@(posedge core_clk) disable iff (!resetn)
        (rdAck && !atZero && runEn) |=> !pending_r)
        else $error("ack did not clear");
    chk_disable_clears: assert property (@(posedge core_clk) disable iff (!resetn)
        !runEn |=> !pending_r && count_r == '0)
        else $error("disable did not clear");
    chk_mask_gate: assert property (@(posedge core_clk) disable iff (!resetn)
        (pending_r && !control_r.irqMask) |-> timerIrq)
        else $error("irq not raised");
    chk_zero_sets: assert property (@(posedge core_clk) disable iff (!resetn)
        atZero |=> pending_r [*1])
        else $error("zero did not set pending");
    chk_reset_state: assert property (@(posedge core_clk)
        (!resetn && heldRst_r) |-> control_r == cdt_pkg::CONTROL_RST
        && reloadValue_r == CNT_W'(cdt_pkg::RELOAD_RST))
        else $error("reset values wrong");
    chk_state_keeps: assert property (@(posedge core_clk) disable iff (!resetn)
        (doRead && s_axi_araddr == cdt_pkg::STATE_OFS && runEn && !atZero)
        |=> pending_r == $past(pending_r))
        else $error("state read changed pending");
    chk_irq_follows: assert property (@(posedge core_clk) disable iff (!resetn)
        (atZero && !control_r.irqMask && !wrControl) |=> timerIrq)
        else $error("zero did not raise irq");
    chk_pending_holds: assert property (@(posedge core_clk) disable iff (!resetn)
        (pending_r && runEn && !rdAck) |=> pending_r)
        else $error("pending dropped without ack");
    chk_ack_zero: assert property (@(posedge core_clk) disable iff (!resetn)
        rdAck |=> s_axi_rdata == 32'h0000_0000)
        else $error("ack read not zero");
    chk_evt_sets: assert property (@(posedge core_clk) disable iff (!resetn)
        atZero |=> evtStat_r)
        else $error("zero did not set event bit");
    chk_evt_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
        (evtStat_r && !rdEvtStat) |=> evtStat_r)
        else $error("event bit not sticky");
    chk_mask_blocks: assert property (@(posedge core_clk) disable iff (!resetn)
        (control_r.irqMask && !(evtStat_r && !evtMask_r)) |-> !timerIrq)
        else $error("masked irq raised");
    chk_idle_count: assert property (@(posedge core_clk) disable iff (!resetn)
        (!runEn && !$past(runEn)) |-> count_r == '0)
        else $error("idle count moved");
endmodule
`default_nettype wire

// ### rtl/cdt_pkg.sv
// constants and carriers shared by the countdown timer design
`default_nettype none
package cdt_pkg;
    localparam int CNT_W = 32;
    // register byte offsets
    localparam logic [7:0] RELOAD_OFS = 8'h00;
    localparam logic [7:0] COUNT_OFS = 8'h04;
    localparam logic [7:0] CONTROL_OFS = 8'h08;
    localparam logic [7:0] ACK_OFS = 8'h0C;
    localparam logic [7:0] STATE_OFS = 8'h10;
    localparam logic [7:0] EVTSTAT_OFS = 8'h14;
    localparam logic [7:0] EVTMASK_OFS = 8'h18;
    // control field positions
    localparam int ENABLE_POS = 0;
    localparam int MODE_POS = 1;
    localparam int MASK_POS = 2;
    // reset values, free-run reload value and bus response codes
    localparam logic [31:0] RELOAD_RST = 32'h0000_0000;
    localparam logic [31:0] FREE_MAX = 32'hFFFF_FFFF;
    localparam logic [2:0] CONTROL_RST = 3'h0;
    localparam logic EVTMASK_RST = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic irqMask;
        logic countMode;
        logic runEnable;
    } control_s;
endpackage
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the countdown timer over its register bus
`default_nettype none
module testbench;
timeunit 1ns;
timeprecision 1ns;
logic clk = 0, rstn = 0, awV = 0, wV = 0, bR = 0, arV = 0, rR = 0;
logic [7:0] awA = '0, arA = '0;
logic [31:0] wD = '0, rD, v, w, r;
logic awRdy, wRdy, bV, arRdy, rV, irq;
logic [1:0] bRsp, rRsp;
int err_count = 0, checks_done = 0, cyc = 0, t1, t2, tX, k;
logic [31:0] mdl [8]; // model of the writable registers, by word index
always #5 clk = ~clk;
countdown_timer_32bit dut (.core_clk(clk), .resetn(rstn), .s_axi_awaddr(awA),
    .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bRsp), .s_axi_bvalid(bV),
    .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy),
    .s_axi_rdata(rD), .s_axi_rresp(rRsp), .s_axi_rvalid(rV), .s_axi_rready(rR),
    .timerIrq(irq));
// ceiling well above the few hundred cycles the sequence needs
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        err_count++;
        finish_test();
    end
end
function automatic logic [1:0] resp(logic [7:0] a, bit wr);
    if (a > 8'h18 || (wr && a != 8'h00 && a != 8'h08 && a != 8'h18))
        return cdt_pkg::RESP_SLVERR;
    return cdt_pkg::RESP_OKAY;
endfunction
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
        err_count++;
        $display("BAD t=%0t got %h want %h", $time, g, e);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awA <= a; wD <= d; awV <= 1; wV <= 1; bR <= 1;
    forever begin
        @(posedge clk);
        if (awV && awRdy) awV <= 0;
        if (wV && wRdy) wV <= 0;
        if (bV) break;
    end
    bR <= 0;
    chk(bRsp, resp(a, 1));
    if (resp(a, 1) == cdt_pkg::RESP_OKAY) mdl[a[4:2]] = d;
endtask
task automatic rd(input logic [7:0] a, output logic [31:0] d, output int t);
    @(posedge clk);
    arA <= a; arV <= 1; rR <= 1;
    forever begin
        @(posedge clk);
        if (arV && arRdy) begin
            arV <= 0;
            t = cyc;
        end
        if (rV) break;
    end
    rR <= 0;
    d = rD;
    chk(rRsp, resp(a, 0));
endtask
task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, v, tX);
    chk(v, e);
endtask
task automatic wirq(output int t);
    k = 0;
    do begin
        @(posedge clk);
        k++;
    end while (!irq && k < 300);
    t = cyc;
    chk(irq, 1);
endtask
task automatic settle;
    @(posedge clk);
    #1;
endtask
task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
initial begin
    void'($urandom(32'hdfdf));
    repeat (2) @(posedge clk);
    rstn <= 1;
    chk(irq, 0);
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h08, 32'h0000_0000);
    rdc(8'h1C, 32'h0000_0000);
    wr(8'h04, $urandom);
    wr(8'h18, 32'h0000_0001);
    rdc(8'h18, mdl[6]);
    $display("reset and map test done");
    r = 32'd20 + $urandom_range(30);
    wr(8'h00, r);
    rdc(8'h00, mdl[0]);
    wr(8'h08, 32'h0000_0001);
    rd(8'h04, v, t1);
    rd(8'h04, w, t2);
    chk(32'(v <= r), 1);
    chk(v - w, 32'(t2 - t1));
    wirq(t1);
    rd(8'h04, v, tX);
    chk(32'(v > 32'hFFFF_FF00), 1);
    rdc(8'h10, 32'h0000_0001);
    rdc(8'h10, 32'h0000_0001);
    rdc(8'h14, 32'h0000_0001);
    rdc(8'h14, 32'h0000_0000);
    rdc(8'h0C, 32'h0000_0000);
    settle();
    chk(irq, 0);
    $display("free-running test done");
    wr(8'h08, 32'h0000_0000);
    wr(8'h00, r);
    wr(8'h08, 32'h0000_0003);
    wirq(t1);
    rdc(8'h0C, 32'h0000_0000);
    wirq(t2);
    chk(32'(t2 - t1), r + 1);
    wr(8'h08, 32'h0000_0007);
    settle();
    chk(irq, 0);
    rdc(8'h10, 32'h0000_0000);
    wr(8'h08, 32'h0000_0003);
    settle();
    chk(irq, 1);
    wr(8'h08, 32'h0000_0002);
    settle();
    chk(irq, 0);
    rd(8'h04, v, tX);
    rd(8'h04, w, tX);
    chk(v, 32'h0000_0000);
    chk(w, v);
    $display("user count test done");
    // a zero reload makes a zero event on every cycle after the load cycle, so the ack always loses
    wr(8'h00, 32'h0000_0000);
    wr(8'h08, 32'h0000_0003);
    rdc(8'h0C, 32'h0000_0000);
    rdc(8'h10, 32'h0000_0001);
    chk(irq, 1);
    $display("set priority test done");
    wr(8'h08, 32'h0000_0006);
    wr(8'h18, 32'h0000_0000);
    settle();
    chk(irq, 1);
    rdc(8'h14, 32'h0000_0001);
    settle();
    chk(irq, 0);
    $display("event status test done");
    wr(8'h00, $urandom);
    @(posedge clk);
    rstn <= 0;
    @(posedge clk);
    rstn <= 1;
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h08, 32'h0000_0000);
    $display("second reset test done");
    finish_test();
end
endmodule
`default_nettype wire
